/* design/llf_lowpass.v */
// lock-in output low-pass filter with key, overload and apb register control
// What this block does
// - time constant code covers 1 us to 30 ks, every decade
// - codes step 1-3 mantissa times 1, 10 or 100 units
// - time constant sets low-pass bandwidth on x and y detector outputs
// - noise bandwidth reported from time constant and slope together
// - slope 6/12/18/24 dB per octave selects 1..4 cascaded poles
// - short slope key press cycles poles 1..4, wrapping to 1
// - long press in rc mode enables advanced filter, lights indicator
// - long press in advanced mode returns to rc, indicator off
// - advanced, tc up to 3 s: each pole becomes equal-enbw fir section
// - advanced, tc 10 s to 1000 s: linear phase mode, same integrate-and-dump fir sections as above
// - advanced, tc above 1000 s: behaves as the rc filter
// - overload flag from selected input path and its range
// - results carry an overload marker while overload is set
// - voltage range ignored while current path selected
// - current range ignored while voltage path selected
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
`include "llf_consts.vh"
module llf_lowpass #(
  parameter DW = 24,
  parameter GUARD = 36,
  parameter CLK_HZ = `LLF_CLK_HZ,
  parameter MS_DIV = `LLF_CLK_HZ / `LLF_MS_PER_S,
  parameter LONG_MS = `LLF_LONG_MS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`LLF_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  input wire [DW-1:0] x_in,
  input wire [DW-1:0] y_in,
  input wire in_valid,
  input wire slope_key_n,
  input wire v_ovld_pin,
  input wire i1u_ovld_pin,
  input wire i10n_ovld_pin,
  output wire [DW-1:0] x_out,
  output wire [DW-1:0] y_out,
  output wire out_valid,
  output wire ovld_mark,
  output wire adv_led,
  output wire [2:0] v_range_out,
  output wire i_range_out,
  output wire isel_out
);
  localparam W = DW + GUARD;
  localparam CW = GUARD + 2;
  localparam [15:0] LONG_CNT = LONG_MS;
  localparam [31:0] MS_LAST = MS_DIV - 1;
  // pin synchroniser: key, voltage, 1 uA and 10 nA comparators
  reg [3:0] s1_ff;
  reg [3:0] s2_ff;
  reg [3:0] s3_ff;
  reg [3:0] pin_ff;
  wire [3:0] pins = {i10n_ovld_pin, i1u_ovld_pin, v_ovld_pin, ~slope_key_n};
  wire [3:0] dis = s2_ff ^ s3_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      s3_ff <= 4'h0;
      pin_ff <= 4'h0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= (s2_ff & ~dis) | (pin_ff & dis);
    end
  end
  wire key_dn = pin_ff[0];
  // registers
  reg [4:0] tc_ff;
  reg [1:0] pol_ff;
  reg adv_ff;
  reg isel_ff;
  reg [2:0] vr_ff;
  reg ir_ff;
  reg [`LLF_EV_W-1:0] ist_ff;
  reg [`LLF_EV_W-1:0] imask_ff;
  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg irq_ff;
  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pready_ff & pwrite;
  wire dec_ctrl = paddr == `LLF_OFS_CTRL;
  wire dec_ok = dec_ctrl | (paddr == `LLF_OFS_STAT) | (paddr == `LLF_OFS_ISTAT)
    | (paddr == `LLF_OFS_IMASK) | (paddr == `LLF_OFS_XOUT)
    | (paddr == `LLF_OFS_YOUT) | (paddr == `LLF_OFS_ENBW);
  wire [4:0] wtc = pwdata[`LLF_CTRL_TC_HI:`LLF_CTRL_TC_LO];
  // filter structure chosen from advanced flag and time constant band
  reg [1:0] mode;
  always @* begin
    mode = `LLF_MODE_RC;
    if (adv_ff && tc_ff <= `LLF_TC_FIR_MAX)
      mode = `LLF_MODE_FIR;
    else if (adv_ff && tc_ff <= `LLF_TC_LP_MAX)
      mode = `LLF_MODE_LP;
    else
      mode = `LLF_MODE_RC;
  end
  // shift k ~ log2(tau * rate); codes step by log2(10)/2, so (5c+1)/3 at 1 MHz rate
  wire [7:0] tc8 = {3'h0, tc_ff};
  wire [7:0] kraw = (tc8 * 8'h05 + 8'h01) / 8'h03;
  wire [5:0] k = kraw[5:0];
  // slope key timing: ms tick then hold counter
  reg [31:0] ms_cnt_ff;
  reg [15:0] hold_ff;
  reg long_done_ff;
  reg key_prev_ff;
  wire ms_tick = ms_cnt_ff == MS_LAST;
  wire key_long = key_dn & ~long_done_ff & (hold_ff == LONG_CNT);
  wire key_short = ~key_dn & key_prev_ff & ~long_done_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_ff <= 32'h0;
      hold_ff <= 16'h0;
      long_done_ff <= 1'b0;
      key_prev_ff <= 1'b0;
    end else begin
      key_prev_ff <= key_dn;
      ms_cnt_ff <= ms_tick ? 32'h0 : ms_cnt_ff + 32'h1;
      if (!key_dn) begin
        hold_ff <= 16'h0;
        long_done_ff <= 1'b0;
      end else begin
        if (ms_tick && hold_ff != LONG_CNT)
          hold_ff <= hold_ff + 16'h1;
        if (key_long)
          long_done_ff <= 1'b1;
      end
    end
  end
  // overload from the selected path only
  wire i_ovld = ir_ff ? pin_ff[3] : pin_ff[2];
  wire ovld_now = isel_ff ? i_ovld : pin_ff[1];
  reg ovld_prev_ff;
  wire [`LLF_EV_W-1:0] ev;
  assign ev[`LLF_EV_OVLD] = ovld_now & ~ovld_prev_ff;
  assign ev[`LLF_EV_KEY] = key_long | key_short;
  // register writes; key events win over a simultaneous bus write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_ff <= `LLF_RST_TC;
      pol_ff <= `LLF_RST_POL;
      adv_ff <= `LLF_RST_ADV;
      isel_ff <= 1'b0;
      vr_ff <= `LLF_RST_VR;
      ir_ff <= 1'b0;
      ist_ff <= {`LLF_EV_W{1'b0}};
      imask_ff <= {`LLF_EV_W{1'b0}};
      ovld_prev_ff <= 1'b0;
    end else begin
      ovld_prev_ff <= ovld_now;
      if (wr_go && dec_ctrl) begin
        if (wtc <= `LLF_TC_MAX)
          tc_ff <= wtc;
        pol_ff <= pwdata[`LLF_CTRL_POL_HI:`LLF_CTRL_POL_LO];
        adv_ff <= pwdata[`LLF_CTRL_ADV];
        isel_ff <= pwdata[`LLF_CTRL_ISEL];
        vr_ff <= pwdata[`LLF_CTRL_VR_HI:`LLF_CTRL_VR_LO];
        ir_ff <= pwdata[`LLF_CTRL_IR];
      end
      if (key_short)
        pol_ff <= pol_ff + 2'h1;
      if (key_long)
        adv_ff <= ~adv_ff;
      if (wr_go && paddr == `LLF_OFS_IMASK)
        imask_ff <= pwdata[`LLF_EV_W-1:0];
      // set wins over write-one-to-clear
      if (wr_go && paddr == `LLF_OFS_ISTAT)
        ist_ff <= (ist_ff & ~pwdata[`LLF_EV_W-1:0]) | ev;
      else
        ist_ff <= ist_ff | ev;
    end
  end
  // noise bandwidth factor per pole count, scaled by rate / 2^k
  reg [15:0] enbw_f;
  always @* begin
    case (pol_ff)
      2'h0: enbw_f = `LLF_ENBW_P1;
      2'h1: enbw_f = `LLF_ENBW_P2;
      2'h2: enbw_f = `LLF_ENBW_P3;
      2'h3: enbw_f = `LLF_ENBW_P4;
      default: enbw_f = `LLF_ENBW_P1;
    endcase
  end
  // filter core: 2 channels x 4 poles, rc recursion or integrate-and-dump
  reg [CW-1:0] dcnt_ff;
  // dump length 2^(k+1) samples gives boxcar enbw 1/(2T) = rc enbw 1/(4 tau)
  wire [CW-1:0] dlen = {{(CW-1){1'b0}}, 1'b1} << (k + 6'h1);
  wire box = mode != `LLF_MODE_RC;
  // a k or mode change restarts the window, else a shorter window is overrun
  reg [5:0] k_prev_ff;
  reg box_prev_ff;
  wire chg = (k != k_prev_ff) | (box != box_prev_ff);
  wire dump = ~chg & (dcnt_ff == dlen - {{(CW-1){1'b0}}, 1'b1});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_ff <= {CW{1'b0}};
      k_prev_ff <= 6'h0;
      box_prev_ff <= 1'b0;
    end else begin
      k_prev_ff <= k;
      box_prev_ff <= box;
      if (chg)
        dcnt_ff <= {CW{1'b0}};
      else if (in_valid)
        dcnt_ff <= dump ? {CW{1'b0}} : dcnt_ff + {{(CW-1){1'b0}}, 1'b1};
    end
  end
  wire [W-1:0] st_out [0:7];
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pole
      wire [W-1:0] src;
      wire [W-1:0] y_w;
      if (g % 4 == 0) begin : g_first
        wire [DW-1:0] raw = (g == 0) ? x_in : y_in;
        assign src = {raw, {GUARD{1'b0}}};
      end else begin : g_next
        assign src = st_out[g-1];
      end
      llf_pole #(
        .W(W),
        .GUARD(GUARD)
      ) u_llf_pole (
        .pclk(pclk),
        .presetn(presetn),
        .upd(in_valid),
        .box(box),
        .dump(dump),
        .clr(chg),
        .k(k),
        .src(src),
        .y(y_w)
      );
      assign st_out[g] = y_w;
    end
  endgenerate
  reg [DW-1:0] x_out_ff;
  reg [DW-1:0] y_out_ff;
  reg out_valid_ff;
  reg ovld_mark_ff;
  wire [2:0] last_x = {1'b0, pol_ff};
  wire [2:0] last_y = 3'h4 + {1'b0, pol_ff};
  wire [W-1:0] xs = st_out[last_x];
  wire [W-1:0] ys = st_out[last_y];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_out_ff <= {DW{1'b0}};
      y_out_ff <= {DW{1'b0}};
      out_valid_ff <= 1'b0;
      ovld_mark_ff <= 1'b0;
    end else begin
      out_valid_ff <= in_valid;
      ovld_mark_ff <= ovld_now;
      if (in_valid) begin
        x_out_ff <= xs[W-1:GUARD];
        y_out_ff <= ys[W-1:GUARD];
      end
    end
  end
  // apb slave: data and pready registered in setup, access always one cycle
  reg [31:0] rd;
  always @* begin
    rd = 32'h0;
    case (paddr)
      `LLF_OFS_CTRL: rd = {19'h0, ir_ff, vr_ff, isel_ff, adv_ff, pol_ff, tc_ff};
      `LLF_OFS_STAT: rd = {28'h0, adv_ff, mode, ovld_now};
      `LLF_OFS_ISTAT: rd = {{(32-`LLF_EV_W){1'b0}}, ist_ff};
      `LLF_OFS_IMASK: rd = {{(32-`LLF_EV_W){1'b0}}, imask_ff};
      `LLF_OFS_XOUT: rd = {{(32-DW){x_out_ff[DW-1]}}, x_out_ff};
      `LLF_OFS_YOUT: rd = {{(32-DW){y_out_ff[DW-1]}}, y_out_ff};
      `LLF_OFS_ENBW: rd = {10'h0, k, enbw_f};
      default: rd = 32'h0;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0 : rd;
        pslverr_ff <= ~dec_ok;
      end
      irq_ff <= |(ist_ff & imask_ff);
    end
  end
  reg adv_led_ff;
  reg [2:0] vr_out_ff;
  reg ir_out_ff;
  reg isel_out_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_led_ff <= `LLF_RST_ADV;
      vr_out_ff <= `LLF_RST_VR;
      ir_out_ff <= 1'b0;
      isel_out_ff <= 1'b0;
    end else begin
      adv_led_ff <= adv_ff;
      vr_out_ff <= vr_ff;
      ir_out_ff <= ir_ff;
      isel_out_ff <= isel_ff;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign x_out = x_out_ff;
  assign y_out = y_out_ff;
  assign out_valid = out_valid_ff;
  assign ovld_mark = ovld_mark_ff;
  assign adv_led = adv_led_ff;
  assign v_range_out = vr_out_ff;
  assign i_range_out = ir_out_ff;
  assign isel_out = isel_out_ff;
endmodule // llf_lowpass

// one filter pole: rc recursion or integrate-and-dump section
module llf_pole #(
  parameter W = 60,
  parameter GUARD = 36
) (
  input wire pclk,
  input wire presetn,
  input wire upd,
  input wire box,
  input wire dump,
  input wire clr,
  input wire [5:0] k,
  input wire [W-1:0] src,
  output wire [W-1:0] y
);
  // head room for 2^(k+1) summed samples at the largest k
  localparam AW = W + GUARD + 1;
  reg [W-1:0] y_ff;
  reg [AW-1:0] acc_ff;
  wire [W:0] diff = {src[W-1], src} - {y_ff[W-1], y_ff};
  wire [W:0] step = $signed(diff) >>> k;
  wire [AW-1:0] acc_n = acc_ff + {{(AW-W){src[W-1]}}, src};
  wire [AW-1:0] mean = $signed(acc_n) >>> (k + 6'h1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_ff <= {W{1'b0}};
      acc_ff <= {AW{1'b0}};
    end else if (upd && !box) begin
      y_ff <= y_ff + step[W-1:0];
      acc_ff <= {AW{1'b0}};
    end else if (clr) begin
      acc_ff <= {AW{1'b0}};
    end else if (upd) begin
      if (dump) begin
        y_ff <= mean[W-1:0];
        acc_ff <= {AW{1'b0}};
      end else begin
        acc_ff <= acc_n;
      end
    end
  end
  assign y = y_ff;
endmodule // llf_pole

/* pkg/llf_consts.vh */
// constants for the lock-in output low-pass filter block
`ifndef LLF_CONSTS_VH
`define LLF_CONSTS_VH
`define LLF_ADDR_W 8
`define LLF_OFS_CTRL 8'h00
`define LLF_OFS_STAT 8'h04
`define LLF_OFS_ISTAT 8'h08
`define LLF_OFS_IMASK 8'h0C
`define LLF_OFS_XOUT 8'h10
`define LLF_OFS_YOUT 8'h14
`define LLF_OFS_ENBW 8'h18
`define LLF_CTRL_TC_LO 0
`define LLF_CTRL_TC_HI 4
`define LLF_CTRL_POL_LO 5
`define LLF_CTRL_POL_HI 6
`define LLF_CTRL_ADV 7
`define LLF_CTRL_ISEL 8
`define LLF_CTRL_VR_LO 9
`define LLF_CTRL_VR_HI 11
`define LLF_CTRL_IR 12
`define LLF_RST_TC 5'h0A
`define LLF_RST_POL 2'h0
`define LLF_RST_ADV 1'b1
`define LLF_RST_VR 3'h0
`define LLF_TC_MAX 5'h15
`define LLF_TC_FIR_MAX 5'h0D
`define LLF_TC_LP_MAX 5'h12
`define LLF_MODE_RC 2'h0
`define LLF_MODE_FIR 2'h1
`define LLF_MODE_LP 2'h2
`define LLF_EV_OVLD 0
`define LLF_EV_KEY 1
`define LLF_EV_W 2
`define LLF_ENBW_P1 16'h4000
`define LLF_ENBW_P2 16'h2000
`define LLF_ENBW_P3 16'h1800
`define LLF_ENBW_P4 16'h1400
`define LLF_CLK_HZ 100000000
`define LLF_MS_PER_S 1000
`define LLF_LONG_MS 1000
`endif

/* testbench/llf_lowpass_assertions.sv */
// port assertions for the low-pass filter block
`timescale 1ns/100ps
`include "llf_consts.vh"
module llf_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`LLF_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire in_valid,
  input wire out_valid,
  input wire slope_key_n,
  input wire v_ovld_pin,
  input wire i1u_ovld_pin,
  input wire i10n_ovld_pin,
  input wire ovld_mark,
  input wire adv_led,
  input wire [2:0] v_range_out,
  input wire i_range_out,
  input wire isel_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_ctrl_wr; pready && pwrite && paddr == `LLF_OFS_CTRL; endsequence
  a_ready_next: assert property (s_setup |=> pready && penable)
    else $error("no pready after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_unmapped: assert property (pready && paddr > `LLF_OFS_ENBW |-> pslverr)
    else $error("no pslverr on unmapped");
  a_valid_follows: assert property (in_valid |=> out_valid)
    else $error("out_valid missing");
  a_valid_quiet: assert property (!in_valid |=> !out_valid)
    else $error("stray out_valid");
  a_ctrl_copy: assert property (s_ctrl_wr |-> ##2
    {v_range_out, i_range_out, isel_out} == $past({pwdata[11:9], pwdata[12], pwdata[8]}, 2))
    else $error("range copies wrong");
  a_ovld_volt: assert property (
    (!isel_out && v_ovld_pin) [*6] ##1 !isel_out |-> ovld_mark)
    else $error("voltage overload not flagged");
  a_volt_ignored: assert property (
    (isel_out && !i1u_ovld_pin && !i10n_ovld_pin) [*6] ##1 isel_out |-> !ovld_mark)
    else $error("voltage overload seen on current path");
  a_curr_ignored: assert property (
    (!isel_out && !v_ovld_pin) [*6] ##1 !isel_out |-> !ovld_mark)
    else $error("current overload seen on voltage path");
  a_adv_cause: assert property (
    $changed(adv_led) |-> !slope_key_n || $past(pready && pwrite, 2))
    else $error("advanced flag changed without cause");
endmodule // llf_chk
bind llf_lowpass llf_chk u_llf_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .in_valid, .out_valid, .slope_key_n, .v_ovld_pin,
  .i1u_ovld_pin, .i10n_ovld_pin, .ovld_mark, .adv_led, .v_range_out, .i_range_out, .isel_out);

/* testbench/llf_lowpass_tb.sv */
// self-checking bench for the low-pass filter block
`timescale 1ns/100ps
`include "llf_consts.vh"
module llf_lowpass_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, in_valid = 0, er;
  reg slope_key_n = 1, v_ovld_pin = 0, i1u_ovld_pin = 0, i10n_ovld_pin = 0;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [23:0] x_in = 0, y_in = 0;
  reg [25:0] tab [0:6];
  wire [31:0] prdata;
  wire [23:0] x_out, y_out;
  wire [2:0] v_range_out;
  wire pready, pslverr, irq, out_valid, ovld_mark, adv_led, i_range_out, isel_out;
  integer errors = 0, comparisons = 0, cyc = 0, i, k;
  // short ms tick and long-press count keep key tests brief
  llf_lowpass #(.MS_DIV(10), .LONG_MS(3)) u_llf_lowpass (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .x_in, .y_in, .in_valid, .slope_key_n, .v_ovld_pin, .i1u_ovld_pin, .i10n_ovld_pin,
    .x_out, .y_out, .out_valid, .ovld_mark, .adv_led, .v_range_out, .i_range_out, .isel_out
  );
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
      apb(0, a, 0);
      chk(rd & m, e);
    end
  endtask
  task samp(input [23:0] v, input [23:0] e);
    begin
      x_in <= v;
      y_in <= v;
      // outputs show the state before each update, so look after a second sample
      in_valid <= 1;
      repeat (2) @(posedge pclk);
      in_valid <= 0;
      #1;
      chk(out_valid, 1);
      chk(x_out, e);
      chk(y_out, e);
    end
  endtask
  // key is released 40 cycles so the debouncer settles before the next press
  task press(input integer n);
    begin
      slope_key_n <= 0;
      repeat (n) @(posedge pclk);
      slope_key_n <= 1;
      repeat (40) @(posedge pclk);
    end
  endtask
  initial begin
    tab[0] = {1'b1, 2'h0, 5'h00, `LLF_MODE_FIR, `LLF_ENBW_P1};
    tab[1] = {1'b1, 2'h1, 5'h0D, `LLF_MODE_FIR, `LLF_ENBW_P2};
    tab[2] = {1'b1, 2'h2, 5'h0E, `LLF_MODE_LP, `LLF_ENBW_P3};
    tab[3] = {1'b1, 2'h3, 5'h12, `LLF_MODE_LP, `LLF_ENBW_P4};
    tab[4] = {1'b1, 2'h0, 5'h13, `LLF_MODE_RC, `LLF_ENBW_P1};
    tab[5] = {1'b1, 2'h3, 5'h15, `LLF_MODE_RC, `LLF_ENBW_P4};
    tab[6] = {1'b0, 2'h1, 5'h0A, `LLF_MODE_RC, `LLF_ENBW_P2};
    repeat (5) @(posedge pclk);
    chk(adv_led, 1);
    chk(irq, 0);
    presetn <= 1;
    @(posedge pclk);
    rdc(`LLF_OFS_CTRL, 32'h0000008A, 32'h00001FFF);
    for (i = 0; i < 7; i = i + 1) begin
      k = (5 * tab[i][22:18] + 1) / 3;
      apb(1, `LLF_OFS_CTRL, {24'h0, tab[i][25:18]});
      rdc(`LLF_OFS_CTRL, tab[i][25:18], 32'h000000FF);
      rdc(`LLF_OFS_STAT, {tab[i][25], tab[i][17:16], 1'b0}, 32'h0000000E);
      rdc(`LLF_OFS_ENBW, {k[5:0], tab[i][15:0]}, 32'h003FFFFF);
    end
    apb(1, `LLF_OFS_CTRL, 32'h00000016);
    rdc(`LLF_OFS_CTRL, 32'h0000000A, 32'h0000001F);
    apb(0, 8'h1C, 32'h0);
    chk(er, 1);
    chk(rd, 0);
    apb(1, `LLF_OFS_CTRL, 32'h00000000);
    samp(24'h000100, 24'h000100);
    apb(1, `LLF_OFS_CTRL, 32'h00000001);
    samp(24'h000500, 24'h000200);
    apb(1, `LLF_OFS_IMASK, 32'h00000002);
    apb(1, `LLF_OFS_CTRL, 32'h0000006A);
    press(8);
    rdc(`LLF_OFS_CTRL, 32'h0000000A, 32'h000000FF);
    chk(irq, 1);
    apb(1, `LLF_OFS_ISTAT, 32'h00000003);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    press(60);
    chk(adv_led, 1);
    press(60);
    chk(adv_led, 0);
    rdc(`LLF_OFS_CTRL, 32'h0000000A, 32'h000000FF);
    apb(1, `LLF_OFS_ISTAT, 32'h00000003);
    apb(1, `LLF_OFS_IMASK, 32'h00000001);
    v_ovld_pin <= 1;
    repeat (10) @(posedge pclk);
    chk(ovld_mark, 1);
    chk(irq, 1);
    rdc(`LLF_OFS_STAT, 32'h00000001, 32'h00000001);
    v_ovld_pin <= 0;
    apb(1, `LLF_OFS_ISTAT, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    apb(1, `LLF_OFS_IMASK, 32'h00000000);
    v_ovld_pin <= 1;
    repeat (10) @(posedge pclk);
    chk(irq, 0);
    rdc(`LLF_OFS_ISTAT, 32'h00000001, 32'h00000001);
    apb(1, `LLF_OFS_CTRL, 32'h0000010A);
    repeat (10) @(posedge pclk);
    chk(ovld_mark, 0);
    i10n_ovld_pin <= 1;
    repeat (10) @(posedge pclk);
    chk(ovld_mark, 0);
    chk(isel_out, 1);
    i1u_ovld_pin <= 1;
    repeat (10) @(posedge pclk);
    chk(ovld_mark, 1);
    apb(1, `LLF_OFS_CTRL, 32'h0000100A);
    v_ovld_pin <= 0;
    repeat (10) @(posedge pclk);
    chk(ovld_mark, 0);
    give_verdict;
  end
endmodule // llf_lowpass_tb
